// File: verilog/ccsd_clock_gen.sv
// core clock speed doubler: halving divider, bypass and glitch-free mode switch
//
// Contract
// - A divide-by-two stage sits between the crystal clock input and the core phase generator clock.
// - In standard mode core and every peripheral run from the halved clock, never from the raw crystal.
// - With double speed selected the divider is bypassed and core and peripherals run from the crystal.
// - The speed select bit is taken over only on a rising edge of the halved crystal clock.
// - A machine cycle is twelve clock periods with the select clear and six with it set, switchable anytime.
// - After reset the select bit is clear and standard mode runs until software sets it.
// - In double speed every clock-timed peripheral sees its time reference halved.
// - The select is bit 0 of the clock control register at 8Fh; bits 7 to 1 are reserved.
`timescale 1ns/10ps
`default_nettype none

module ccsd_clock_gen (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // crystal pin
  input wire logic crystal_clock_input,
  // special function register access from the core
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  output logic [7:0] sfr_rdata,
  // generated clocks and status
  output logic core_clk,
  output logic periph_tick,
  output logic double_speed_active,
  output logic [3:0] cycle_periods
);
  import ccsd_pkg::*;

  // ----------------------------------------------------------------
  // crystal pin
  // ----------------------------------------------------------------
  logic xtal_lvl;
  logic xtal_d_reg;
  logic xtal_rise;

  ccsd_pin_sync #(
    .STAGES(CCSD_SYNC_STAGES)
  ) u_xtal_sync (
    .clk(clk),
    .resetn(resetn),
    .pin_in(crystal_clock_input),
    .level_out(xtal_lvl)
  );

  assign xtal_rise = xtal_lvl & ~xtal_d_reg;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic double_speed_select_reg;
  logic half_reg;
  logic half_next;
  logic half_rise;
  ccsd_mode_t mode_reg;
  ccsd_mode_t mode_next;
  logic core_clk_reg;
  logic core_clk_next;
  logic tick_reg;
  logic [7:0] rdata_reg;
  logic [3:0] periods_reg;
  logic double_reg;
  logic sfr_hit;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // applied mode decode, shared by the clock mux, the status flops and the checks
  function automatic logic is_double(input ccsd_mode_t m);
    return (m == MODE_DOUBLE);
  endfunction : is_double

  assign half_next = xtal_rise ? ~half_reg : half_reg;
  assign half_rise = xtal_rise & ~half_reg;

  // select taken only at halved rising edge
  // both sources are high at that instant, so neither phase is clipped
  assign mode_next = half_rise ? (double_speed_select_reg ? MODE_DOUBLE : MODE_STANDARD) : mode_reg;

  // source chosen by the applied mode
  assign core_clk_next = is_double(mode_next) ? xtal_lvl : half_next;

  assign sfr_hit = (sfr_addr == CCSD_CLOCK_CONTROL_ADDR);

  // ----------------------------------------------------------------
  // clocked state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xtal_d_reg <= 1'h0;
      half_reg <= 1'h0;
    end else begin
      xtal_d_reg <= xtal_lvl;
      half_reg <= half_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      double_speed_select_reg <= CCSD_SELECT_RESET;
    end else if (sfr_we && sfr_hit) begin
      double_speed_select_reg <= sfr_wdata[CCSD_SELECT_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else if (sfr_re && sfr_hit) begin
      rdata_reg <= CCSD_RESERVED_READ | {7'h00, double_speed_select_reg};
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // one tick per core clock rise; peripherals count these
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= MODE_STANDARD;
      core_clk_reg <= 1'h0;
      tick_reg <= 1'h0;
      periods_reg <= CCSD_PERIODS_STANDARD;
      double_reg <= 1'h0;
    end else begin
      mode_reg <= mode_next;
      core_clk_reg <= core_clk_next;
      tick_reg <= core_clk_next & ~core_clk_reg;
      periods_reg <= is_double(mode_next) ? CCSD_PERIODS_DOUBLE : CCSD_PERIODS_STANDARD;
      double_reg <= is_double(mode_next);
    end
  end

  assign sfr_rdata = rdata_reg;
  assign core_clk = core_clk_reg;
  assign periph_tick = tick_reg;
  // own flop so the status pin carries no decode glitch
  assign double_speed_active = double_reg;
  assign cycle_periods = periods_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_half_rise;
    xtal_rise && !half_reg;
  endsequence

  sequence s_mode_held;
    (mode_reg == $past(mode_reg));
  endsequence

  chk_half_toggle: assert property (xtal_rise |=> half_reg != $past(half_reg))
    else $error("divider did not toggle on crystal rise");

  sequence s_read_hit;
    sfr_re && sfr_hit;
  endsequence

  sequence s_double_low;
    is_double(mode_next) && !xtal_lvl;
  endsequence

  chk_std_from_half: assert property ((mode_reg == MODE_STANDARD) and s_mode_held |-> core_clk_reg == half_reg)
    else $error("standard mode core clock not from halved clock");

  chk_std_fall: assert property (xtal_rise && half_reg && !is_double(mode_next) |=> !core_clk_reg)
    else $error("standard mode core clock missed its fall");

  chk_double_bypass: assert property ((mode_reg == MODE_DOUBLE) and s_mode_held |-> core_clk_reg == xtal_d_reg)
    else $error("double mode core clock not from crystal");

  chk_double_low: assert property (s_double_low |=> !core_clk_reg)
    else $error("double mode core clock high while crystal low");

  chk_active_flag: assert property (double_speed_active == is_double(mode_reg))
    else $error("double speed status differs from applied mode");

  chk_std_stays: assert property ((mode_reg == MODE_STANDARD) && !double_speed_select_reg |=> mode_reg == MODE_STANDARD)
    else $error("standard mode left with the select clear");

  chk_switch_on_half: assert property ($changed(mode_reg) |-> $past(half_rise))
    else $error("mode changed away from halved rising edge");

  chk_period_count: assert property (cycle_periods == ((mode_reg == MODE_DOUBLE) ? 4'h6 : 4'hC))
    else $error("machine cycle period count wrong");

  chk_double_needs_set: assert property ($rose(mode_reg == MODE_DOUBLE) |-> $past(double_speed_select_reg))
    else $error("double mode entered without the select bit");

  chk_tick_on_rise: assert property (periph_tick |-> $rose(core_clk_reg))
    else $error("peripheral tick without core clock rise");

  chk_tick_every_rise: assert property ($rose(core_clk_reg) |-> periph_tick)
    else $error("core clock rise without peripheral tick");

  chk_sfr_write: assert property (sfr_we && sfr_hit |=> double_speed_select_reg == $past(sfr_wdata[0]))
    else $error("select bit not written");

  chk_other_addr: assert property (sfr_we && !sfr_hit |=> $stable(double_speed_select_reg))
    else $error("select bit changed by a write to another address");

  chk_read_data: assert property (s_read_hit |=> sfr_rdata == {7'h00, $past(double_speed_select_reg)})
    else $error("read data not the select bit with reserved bits clear");

  chk_read_idle: assert property (!(sfr_re && sfr_hit) |=> sfr_rdata == 8'h00)
    else $error("read data not zero outside a read");

  chk_clean_switch: assert property (s_half_rise ##1 $changed(mode_reg) |-> core_clk_reg && half_reg)
    else $error("mode switch clipped a clock phase");

  chk_switch_high: assert property ($changed(mode_reg) |-> core_clk_reg)
    else $error("mode switch landed on a low core clock phase");

endmodule : ccsd_clock_gen

`default_nettype wire

// File: verilog/ccsd_pkg.sv
// constants shared by the core clock speed doubler
package ccsd_pkg;

  // ----------------------------------------------------------------
  // clock control register
  // ----------------------------------------------------------------
  localparam logic [7:0] CCSD_CLOCK_CONTROL_ADDR = 8'h8F;
  localparam int CCSD_SELECT_BIT = 0;
  localparam logic CCSD_SELECT_RESET = 1'h0;
  localparam logic [7:0] CCSD_RESERVED_READ = 8'h00;

  // ----------------------------------------------------------------
  // machine cycle figures
  // ----------------------------------------------------------------
  localparam logic [3:0] CCSD_PERIODS_STANDARD = 4'hC;
  localparam logic [3:0] CCSD_PERIODS_DOUBLE = 4'h6;

  // ----------------------------------------------------------------
  // pin synchroniser depth
  // ----------------------------------------------------------------
  localparam int CCSD_SYNC_STAGES = 3;

  // applied speed mode, one-hot
  typedef enum logic [1:0] {
    MODE_STANDARD = 2'b01,
    MODE_DOUBLE = 2'b10
  } ccsd_mode_t;

endpackage : ccsd_pkg

// File: verilog/ccsd_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module ccsd_pin_sync #(
  parameter int STAGES = ccsd_pkg::CCSD_SYNC_STAGES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pin side
  input wire logic pin_in,
  // filtered level
  output logic level_out
);
  import ccsd_pkg::*;

  initial begin
    if (STAGES != 3) begin
      $error("ccsd_pin_sync supports exactly three stages");
    end
  end

  logic meta_reg;
  logic second_reg;
  logic third_reg;
  logic level_reg;
  logic level_next;

  // the level only moves once stages two and three agree
  assign level_next = (second_reg == third_reg) ? third_reg : level_reg;
  assign level_out = level_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 1'h0;
      second_reg <= 1'h0;
      third_reg <= 1'h0;
      level_reg <= 1'h0;
    end else begin
      meta_reg <= pin_in;
      second_reg <= meta_reg;
      third_reg <= second_reg;
      level_reg <= level_next;
    end
  end

endmodule : ccsd_pin_sync

`default_nettype wire

// File: tb/ccsd_xtal_model.sv
// crystal oscillator model feeding the clock doubler pin
`timescale 1ns/10ps
`default_nettype none

module ccsd_xtal_model (
  // period control, half period in 20 ns steps
  input wire logic [7:0] half_cyc,
  // crystal pin
  output logic xtal
);
  // runs free like a real crystal; waits 1 ns so the bench has set the period
  initial begin
    xtal = 1'b0;
    #1;
    forever #(half_cyc * 20) xtal = ~xtal;
  end
endmodule : ccsd_xtal_model

`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the core clock speed doubler
`timescale 1ns/10ps
`default_nettype none

module tb;
  import ccsd_pkg::*;
  logic clk, resetn, xtal, sfr_we, sfr_re, core_clk, periph_tick, dsa, prev;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, half_cyc, q;
  logic [3:0] cycle_periods;
  int n_fail = 0;
  int cmp_count = 0;
  int sel_model, ticks, run, min_run;

  ccsd_xtal_model xm (.half_cyc(half_cyc), .xtal(xtal));
  ccsd_clock_gen dut (.clk(clk), .resetn(resetn), .crystal_clock_input(xtal), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata),
    .core_clk(core_clk), .periph_tick(periph_tick), .double_speed_active(dsa),
    .cycle_periods(cycle_periods));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // only runs between two level changes count, so the reset phase is ignored
  always @(posedge clk) begin
    prev <= core_clk;
    if (!resetn) begin
      run <= -99;
      min_run <= 999;
      ticks <= 0;
    end else begin
      if (periph_tick === 1'b1) ticks <= ticks + 1;
      if (core_clk !== prev) begin
        if (run >= 0 && run < min_run) min_run <= run;
        run <= 1;
      end else run <= run + 1;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic wr);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = wr;
    sfr_re = !wr;
    @(negedge clk);
    sfr_we = 1'b0;
    sfr_re = 1'b0;
    q = sfr_rdata;
    if (wr && a == CCSD_CLOCK_CONTROL_ADDR) sel_model = d[0];
  endtask : sfr

  // settle past a pending switch, then count ticks over eight crystal periods
  task automatic count();
    int t0;
    repeat (3) @(posedge xtal);
    t0 = ticks;
    repeat (8) @(posedge xtal);
    check(8'(ticks - t0), 8'(sel_model ? 8 : 4), "ticks");
    check({4'h0, cycle_periods}, {4'h0, sel_model ? CCSD_PERIODS_DOUBLE : CCSD_PERIODS_STANDARD}, "periods");
    check({7'h0, dsa}, 8'(sel_model), "mode");
  endtask : count

  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'hE6A6));
    half_cyc = 8'(6 + $urandom % 8);
    resetn = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_we = 1'b0;
    sfr_re = 1'b0;
    sel_model = 0;
    repeat (2) @(negedge clk);
    check({core_clk, periph_tick, dsa, 1'b0, cycle_periods}, 8'h0C, "reset");
    resetn = 1'b1;
    sfr(CCSD_CLOCK_CONTROL_ADDR, 8'h00, 1'b0);
    check(q, 8'h00, "select after reset");
    count();
    sfr(CCSD_CLOCK_CONTROL_ADDR, 8'($urandom) | 8'h01, 1'b1);
    sfr(CCSD_CLOCK_CONTROL_ADDR, 8'h00, 1'b0);
    check(q, 8'h01, "reserved bits");
    count();
    sfr(8'h90 + 8'($urandom % 16), 8'h00, 1'b1);
    sfr(8'h90, 8'h00, 1'b0);
    check(q, 8'h00, "unmapped read");
    count();
    @(posedge xtal);
    sfr(CCSD_CLOCK_CONTROL_ADDR, 8'h00, 1'b1);
    check({7'h0, dsa}, 8'h01, "early switch");
    count();
    check(8'(min_run >= half_cyc - 1), 8'h01, "short phase");
    give_verdict();
  end
endmodule : tb

`default_nettype wire
